// ---- logic/vfd_ctrl.v ----
// Vacuum fluorescent display controller with serial command input.
`include "vfd_consts.vh"
module vfd_ctrl #(
   parameter SCAN_CYC = `VFD_SCAN_CYC,
   parameter RST_CYC = `VFD_RST_CYC
) (
   input wire clk, // 100 MHz clock
   input wire nrst, // Async reset, active low
   input wire display_test_strap, // Test strap, pulled high
   input wire pattern_select_strap, // Select strap, pulled low
   input wire watchdog_disable_strap, // Low disables watchdog
   input wire watchdog_reset, // Watchdog reset request, high
   input wire serial_command_data, // Serial data from processor
   input wire serial_command_clock, // Serial clock from processor
   output reg ready_to_receive_out, // High holds processor off
   output reg ctrl_reset_out, // Internal reset level
   output reg [10:0] grid_out, // Digit selects, high enables
   output reg [7:0] anode_out, // Segment selects, high lights
   output reg beeper_out, // Beeper drive
   input wire avs_read, // Avalon read
   input wire avs_write, // Avalon write
   input wire [7:0] avs_address, // Avalon byte address
   input wire [31:0] avs_writedata, // Avalon write data
   output reg [31:0] avs_readdata, // Avalon read data
   output wire avs_waitrequest // Avalon wait
);
   localparam ST_RESET = 3'b001;
   localparam ST_FILL = 3'b010;
   localparam ST_RUN = 3'b100;

   reg [2:0] state;
   reg [15:0] rst_cnt;
   reg [3:0] fill_idx;
   reg [1:0] pattern;
   reg [7:0] disp_mem [0:10];
   reg [2:0] dsync;
   reg [2:0] csync;
   reg [2:0] tsync;
   reg [2:0] ssync;
   reg [2:0] wsync;
   reg [2:0] wdsync;
   reg [7:0] shift;
   reg [2:0] bit_cnt;
   reg byte_valid;
   reg [7:0] byte_data;
   reg [15:0] scan_cnt;
   reg [3:0] grid_idx;
   reg [1:0] ctrl;
   reg [3:0] wr_ptr;
   reg bus_ack;
   reg overflow;
   wire sclk_edge;
   wire fifo_ready;
   wire fifo_valid;
   wire [7:0] fifo_data;
   wire wdog_hit;
   wire fifo_pop;

   // Fill pattern for one grid position
   function [7:0] fill_byte;
      input [1:0] pat;
      input [3:0] idx;
      begin
         case (pat)
            `VFD_PAT_OFF: fill_byte = `VFD_SEG_ALL_OFF;
            `VFD_PAT_ON: fill_byte = `VFD_SEG_ALL_ON;
            `VFD_PAT_T1: fill_byte = idx[0] ? `VFD_T1_ODD : `VFD_T1_EVEN;
            default: fill_byte = idx[0] ? `VFD_T2_ODD : `VFD_T2_EVEN;
         endcase
      end
   endfunction

   // Two-flop synchronisers; bit 2 is an extra stage for edge finding
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dsync <= 3'h0;
         csync <= 3'h0;
         tsync <= 3'h7;
         ssync <= 3'h0;
         wsync <= 3'h7;
         wdsync <= 3'h0;
      end else begin
         dsync <= {dsync[1:0], serial_command_data};
         csync <= {csync[1:0], serial_command_clock};
         tsync <= {tsync[1:0], display_test_strap};
         ssync <= {ssync[1:0], pattern_select_strap};
         wsync <= {wsync[1:0], watchdog_disable_strap};
         wdsync <= {wdsync[1:0], watchdog_reset};
      end
   end

   // Rising edge of the synced serial clock
   assign sclk_edge = csync[1] && !csync[2];
   // Grounded strap masks the watchdog
   assign wdog_hit = wdsync[1] && wsync[1];

   // Power-up reset, strap capture, memory fill, then run
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_RESET;
         rst_cnt <= 16'h0000;
         fill_idx <= 4'h0;
         pattern <= `VFD_PAT_ON;
         ctrl_reset_out <= 1'b1;
      end else begin
         case (state)
            ST_RESET: begin
               ctrl_reset_out <= 1'b1;
               if (rst_cnt == RST_CYC[15:0] - 16'h0001) begin
                  // Straps captured only after they have settled
                  pattern <= {tsync[1], ssync[1]};
                  fill_idx <= 4'h0;
                  state <= ST_FILL;
               end else begin
                  rst_cnt <= rst_cnt + 16'h0001;
               end
            end
            ST_FILL: begin
               if (fill_idx == 4'hA) begin
                  ctrl_reset_out <= 1'b0;
                  state <= ST_RUN;
               end else begin
                  fill_idx <= fill_idx + 4'h1;
               end
            end
            ST_RUN: begin
               if (wdog_hit) begin
                  rst_cnt <= 16'h0000;
                  ctrl_reset_out <= 1'b1;
                  state <= ST_RESET;
               end
            end
            default: state <= ST_RESET;
         endcase
      end
   end

   // Ready stays high until reset done; then low while room remains
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ready_to_receive_out <= 1'b1;
      end else begin
         // A watchdog hit raises ready in the same edge as the reset
         ready_to_receive_out <= (state != ST_RUN) || wdog_hit ||
            !fifo_ready;
      end
   end

   // Serial bytes, MSB first; bits only counted while in run state
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift <= 8'h00;
         bit_cnt <= 3'h0;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
         overflow <= 1'b0;
      end else begin
         byte_valid <= 1'b0;
         if (state != ST_RUN) begin
            bit_cnt <= 3'h0;
         end else if (sclk_edge) begin
            shift <= {shift[6:0], dsync[1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               byte_data <= {shift[6:0], dsync[1]};
               byte_valid <= 1'b1;
               if (!fifo_ready) begin
                  overflow <= 1'b1;
               end
            end
         end
      end
   end

   vfd_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(byte_valid),
      .in_ready(fifo_ready),
      .in_data(byte_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // Bytes land in memory in grid order, advancing a write pointer
   assign fifo_pop = fifo_valid && (state == ST_RUN);
   always @(posedge clk) begin
      if (state == ST_FILL) begin
         disp_mem[fill_idx] <= fill_byte(pattern, fill_idx);
      end else if (fifo_pop) begin
         disp_mem[wr_ptr] <= fifo_data;
      end
   end
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= 4'h0;
      end else if (state == ST_FILL) begin
         wr_ptr <= 4'h0;
      end else if (fifo_pop) begin
         wr_ptr <= (wr_ptr == 4'hA) ? 4'h0 : wr_ptr + 4'h1;
      end
   end

   // Grid scan with blanking between digits to avoid ghosting
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scan_cnt <= 16'h0000;
         grid_idx <= 4'h0;
         grid_out <= 11'h000;
         anode_out <= 8'h00;
      end else if (state != ST_RUN) begin
         grid_out <= 11'h000;
         anode_out <= 8'h00;
      end else if (scan_cnt == SCAN_CYC[15:0] - 16'h0001) begin
         scan_cnt <= 16'h0000;
         grid_idx <= (grid_idx == 4'hA) ? 4'h0 : grid_idx + 4'h1;
         grid_out <= 11'h000;
         anode_out <= 8'h00;
      end else begin
         scan_cnt <= scan_cnt + 16'h0001;
         grid_out <= 11'h001 << grid_idx;
         anode_out <= disp_mem[grid_idx];
      end
   end

   // Beeper on for test patterns, or by software
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         beeper_out <= 1'b0;
      end else begin
         beeper_out <= ((state == ST_RUN) && !pattern[1]) ||
            ctrl[`VFD_CTRL_BEEP_BIT];
      end
   end

   // Avalon slave: one wait cycle, then answer
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_ack <= 1'b0;
         ctrl <= `VFD_CTRL_RESET;
         avs_readdata <= 32'h00000000;
      end else begin
         bus_ack <= (avs_read || avs_write) && !bus_ack;
         // Write lands only at the edge where waitrequest is low
         if (avs_write && bus_ack) begin
            if (avs_address == `VFD_ADDR_CTRL) begin
               ctrl <= avs_writedata[1:0];
            end
         end
         if (avs_read && !bus_ack) begin
            if (avs_address == `VFD_ADDR_STATUS) begin
               avs_readdata <= {19'h00000, overflow, beeper_out, pattern,
                  ready_to_receive_out, ctrl_reset_out, state, grid_idx};
            end else if (avs_address == `VFD_ADDR_CTRL) begin
               avs_readdata <= {30'h00000000, ctrl};
            end else if (avs_address == `VFD_ADDR_CMD) begin
               avs_readdata <= {24'h000000, disp_mem[grid_idx]};
            end else if (avs_address == `VFD_ADDR_RDPTR) begin
               avs_readdata <= {28'h0000000, wr_ptr};
            end else begin
               avs_readdata <= `VFD_BAD_DATA;
            end
         end
      end
   end
endmodule

// ---- logic/vfd_consts.vh ----
// Constants for the display controller: straps, scan, timing, map.
`ifndef VFD_CONSTS_VH
`define VFD_CONSTS_VH
`define VFD_NUM_GRIDS 11
`define VFD_SEG_W 8
`define VFD_CLK_MHZ_X100 10000
`define VFD_CTRL_CLK_KHZ 4190
`define VFD_CTRL_PER_PS 238000
`define VFD_CLK_PER_PS 10000
`define VFD_SCAN_US 100
`define VFD_SCAN_CYC ((`VFD_SCAN_US * 100))
`define VFD_RST_US 50
`define VFD_RST_CYC ((`VFD_RST_US * 100))
`define VFD_RDY_CYC 16
`define VFD_PAT_OFF 2'h3
`define VFD_PAT_ON 2'h2
`define VFD_PAT_T1 2'h1
`define VFD_PAT_T2 2'h0
`define VFD_SEG_ALL_OFF 8'h00
`define VFD_SEG_ALL_ON 8'hFF
`define VFD_T1_EVEN 8'h55
`define VFD_T1_ODD 8'hAA
`define VFD_T2_EVEN 8'h0F
`define VFD_T2_ODD 8'hF0
`define VFD_ADDR_OFF 0
`define VFD_ADDR_STATUS 8'h00
`define VFD_ADDR_CTRL 8'h04
`define VFD_ADDR_CMD 8'h08
`define VFD_ADDR_RDPTR 8'h0C
`define VFD_CTRL_WDOG_BIT 0
`define VFD_CTRL_BEEP_BIT 1
`define VFD_CTRL_RESET 2'h0
`define VFD_BAD_DATA 32'hDEADBEEF
`endif

// ---- logic/vfd_fifo.v ----
// Small synchronous FIFO for received command bytes.
module vfd_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk, // System clock
   input wire nrst, // Async reset, active low
   input wire in_valid, // Write request
   output wire in_ready, // Not full
   input wire [WIDTH-1:0] in_data, // Write data
   output wire out_valid, // Not empty
   input wire out_ready, // Read accept
   output wire [WIDTH-1:0] out_data // Head word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire do_wr;
   wire do_rd;

   // Full when pointers differ only in the wrap bit
   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Storage has no reset, only pointers do
   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointer update
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// ---- testbench/vfd_ctrl_asserts.sv ----
// Port assertions for the display controller.
module vfd_ctrl_asserts #(
   parameter SCAN_CYC = 20,
   parameter RST_CYC = 10
) (
   input wire clk, // Clock
   input wire nrst, // Reset
   input wire display_test_strap, // Strap
   input wire pattern_select_strap, // Strap
   input wire watchdog_disable_strap, // Strap
   input wire watchdog_reset, // Watchdog
   input wire serial_command_data, // Link
   input wire serial_command_clock, // Link
   input wire ready_to_receive_out, // Ready
   input wire ctrl_reset_out, // Reset out
   input wire [10:0] grid_out, // Grids
   input wire [7:0] anode_out, // Anodes
   input wire beeper_out, // Beeper
   input wire avs_read, // Bus
   input wire avs_write, // Bus
   input wire [7:0] avs_address, // Bus
   input wire [31:0] avs_writedata, // Bus
   input wire [31:0] avs_readdata, // Bus
   input wire avs_waitrequest // Bus
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Reset must hold for 8 cycles after power-up, and end by cycle 60
   rst_min_a: assert property ($rose(nrst) |-> ctrl_reset_out [*8])
      else $error("ctrl reset ended early");
   rst_end_a: assert property ($rose(nrst) |-> ##[10:60] !ctrl_reset_out)
      else $error("ctrl reset never ended");
   // The processor is held off until the fill is over
   rdy_hold_a: assert property (ctrl_reset_out |-> ready_to_receive_out)
      else $error("ready low during reset");
   rdy_fall_a: assert property ($fell(ctrl_reset_out) |=> !ready_to_receive_out)
      else $error("ready not low after reset");
   beep_test_a: assert property ($fell(ctrl_reset_out) && !display_test_strap
      |-> ##[0:2] beeper_out)
      else $error("beeper off on test pattern");
   // Strap is checked settled, as it passes two sync flops
   wdog_off_a: assert property (!watchdog_disable_strap && watchdog_reset &&
      !$past(watchdog_disable_strap, 4) && !ctrl_reset_out |=> !ctrl_reset_out)
      else $error("watchdog reset while disabled");
   grid_hot_a: assert property ($onehot0(grid_out))
      else $error("two grids on");
   grid_wrap_a: assert property ($fell(grid_out[10])
      |-> ##[0:3] (grid_out[0] || ctrl_reset_out))
      else $error("scan did not wrap");
   cover property ($fell(ready_to_receive_out));
   cover property ($rose(beeper_out));
   cover property ($fell(grid_out[10]));
endmodule

// ---- testbench/vfd_host.sv ----
// Behavioural main processor sending serial command bytes.
module vfd_host (
   output logic serial_command_data, // Data to controller
   output logic serial_command_clock, // Link clock
   input wire ready_to_receive_out // Low allows sending
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_command_data = 1'h0;
      serial_command_clock = 1'h0;
   end
   // Clock stands low between bytes; data inverts so stale bits mislead
   task automatic send(input logic [7:0] b);
      int i;
      i = 0;
      while (ready_to_receive_out !== 1'h0 && i < 1000) begin
         #10;
         i++;
      end
      for (i = 7; i >= 0; i--) begin
         #3 serial_command_data = b[i];
         #37 serial_command_clock = 1'h1;
         #80 serial_command_clock = 1'h0;
         #40;
      end
      serial_command_data = ~serial_command_data;
   endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the display controller.
`include "vfd_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam SCAN_CYC = 20;
   localparam RST_CYC = 10;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic display_test_strap = 1'h1;
   logic pattern_select_strap = 1'h0;
   logic watchdog_disable_strap = 1'h1;
   logic watchdog_reset = 1'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   wire serial_command_data, serial_command_clock, ready_to_receive_out;
   wire ctrl_reset_out, beeper_out, avs_waitrequest;
   wire [10:0] grid_out;
   wire [7:0] anode_out;
   wire [31:0] avs_readdata;
   int mismatches = 0;
   int tests_run = 0;
   int i, k;
   logic [18:0] rows [4];
   logic [31:0] q;
   always #5 clk = ~clk;
   vfd_ctrl #(.SCAN_CYC(SCAN_CYC), .RST_CYC(RST_CYC)) vfd_ctrl_i (.*);
   vfd_host vfd_host_i (.*);
   task automatic results;
      $display("Tests %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic fail;
      mismatches++;
      results();
   endtask
   // One bus cycle; an edge passes first so no signal is set twice at once
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int c;
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      c = 0;
      // Waitrequest is looked at mid-cycle, where it has settled
      do begin
         @(negedge clk);
         c++;
      end while (avs_waitrequest !== 1'h0 && c < 50);
      if (c >= 50) fail();
      @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic boot(input logic [1:0] s);
      int c;
      nrst <= 1'h0;
      {display_test_strap, pattern_select_strap} <= s;
      repeat (8) @(posedge clk);
      nrst <= 1'h1;
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (ready_to_receive_out !== 1'h0 && c < 200);
      if (c >= 200) fail();
   endtask
   task automatic grid_is(input int g, input logic [7:0] e);
      int c;
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (grid_out !== (11'h001 << g) && c < 1000);
      if (c >= 1000) fail();
      chk(32'(anode_out), 32'(e));
   endtask
   initial begin
      rows[0] = {`VFD_PAT_OFF, 1'h0, `VFD_SEG_ALL_OFF, `VFD_SEG_ALL_OFF};
      rows[1] = {`VFD_PAT_ON, 1'h0, `VFD_SEG_ALL_ON, `VFD_SEG_ALL_ON};
      rows[2] = {`VFD_PAT_T1, 1'h1, `VFD_T1_EVEN, `VFD_T1_ODD};
      rows[3] = {`VFD_PAT_T2, 1'h1, `VFD_T2_EVEN, `VFD_T2_ODD};
      // Each row: straps, beeper, even and odd grid patterns
      for (i = 0; i < 4; i++) begin
         boot(rows[i][18:17]);
         chk(32'(beeper_out), 32'(rows[i][16]));
         bus(1'h0, `VFD_ADDR_STATUS, 32'h0);
         chk(32'({q[10:9], q[11]}), 32'(rows[i][18:16]));
         for (k = 0; k < 11; k++)
            grid_is(k, k[0] ? rows[i][7:0] : rows[i][15:8]);
         $display("Pattern row %0d done", i);
      end
      // Bytes land on grids 0..10 in turn, sent MSB first
      boot(`VFD_PAT_OFF);
      for (k = 0; k < 11; k++)
         vfd_host_i.send({k[3:0], ~k[3:0]});
      for (k = 0; k < 11; k++)
         grid_is(k, {k[3:0], ~k[3:0]});
      $display("Serial test done");
      // Register bus, unmapped place included
      bus(1'h1, `VFD_ADDR_CTRL, 32'h2);
      bus(1'h1, 8'h10, 32'h0);
      bus(1'h0, `VFD_ADDR_CTRL, 32'h0);
      chk(32'(q[1:0]), 32'h2);
      chk(32'(beeper_out), 32'h1);
      bus(1'h0, 8'h10, 32'h0);
      chk(q, `VFD_BAD_DATA);
      $display("Bus test done");
      // Grounded strap must block the watchdog
      watchdog_disable_strap <= 1'h0;
      repeat (6) @(posedge clk);
      watchdog_reset <= 1'h1;
      repeat (4) @(posedge clk);
      watchdog_reset <= 1'h0;
      repeat (2) @(posedge clk);
      chk(32'(ctrl_reset_out), 32'h0);
      chk(32'(ready_to_receive_out), 32'h0);
      // Strap high again: the watchdog must now reset the controller
      watchdog_disable_strap <= 1'h1;
      repeat (3) @(posedge clk);
      watchdog_reset <= 1'h1;
      repeat (6) @(posedge clk);
      watchdog_reset <= 1'h0;
      chk(32'(ctrl_reset_out), 32'h1);
      chk(32'(ready_to_receive_out), 32'h1);
      $display("Watchdog test done");
      results();
   end
endmodule
bind vfd_ctrl vfd_ctrl_asserts #(.SCAN_CYC(SCAN_CYC), .RST_CYC(RST_CYC)) chk_i (.*);
